// ==== design/sram_core_defs.svh ====
`ifndef SRAM_CORE_DEFS_SVH
`define SRAM_CORE_DEFS_SVH
`define ADDR_W       15
`define DATA_W       18
`define LANE_W       9
`define WORDS        32768
`define BURST_W      2
`define BURST_LAST   2'h3
`define OE_IDLE      1'h1
`endif

// ==== design/sram_core_pkg.sv ====
package sram_core_pkg;
   typedef enum logic [1:0]
   {
      ST_DESEL  = 2'b00,
      ST_READ   = 2'b01,
      ST_WRITE  = 2'b11
   } access_t;
endpackage

// ==== design/sram_array.sv ====
`timescale 1ns/10ps
`include "sram_core_defs.svh"
module sram_array
#(
   parameter int ADDR_W = `ADDR_W,
   parameter int LANE_W = `LANE_W
)
(
   // Clock
   input  wire logic                  i_ref_clk,
   // Access
   input  wire logic [ADDR_W-1:0]     i_addr,
   input  wire logic [1:0]            i_lane_we,
   input  wire logic [2*LANE_W-1:0]   i_wdata,
   output logic      [2*LANE_W-1:0]   o_rdata
);
   // Byte lanes written independently, one array each
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1)
      begin : g_lane
         logic [LANE_W-1:0] mem_q [0:(1<<ADDR_W)-1];

         always_ff @(posedge i_ref_clk)
         begin
            if (i_lane_we[g])
            begin
               mem_q[i_addr] <= i_wdata[g*LANE_W +: LANE_W];
            end
         end

         assign o_rdata[g*LANE_W +: LANE_W] = mem_q[i_addr];
      end
   endgenerate
endmodule // sram_array

// ==== design/sync_burst_sram_core.sv ====
`timescale 1ns/10ps
`include "sram_core_defs.svh"
// Summary of operation
// - Address, data, controls registered on rising clock
// - Array of 32768 words by 18 bits
// - Two-bit counter supplies later burst low bits
// - Either address strobe starts burst, loads base
// - Later addresses internal, stepped by advance, interleaved
// - Writes start at clock edge, self-timed
// - Low enable bits 0-8, high bits 9-17
// - Output drive enabled asynchronously by output enable
// - Shared pins carry write and read data
// - Processor strobe forces read at new address
// - Controller strobe alone: read or write
// - Chip enable sampled on loads; high deselects
// - Advance low steps, high waits, wraps after four
module sync_burst_sram_core
#(
   parameter int ADDR_W = `ADDR_W,
   parameter int DATA_W = `DATA_W
)
(
   // Clock and reset
   input  wire logic               i_ref_clk,
   input  wire logic               i_reset,
   // Control pins, active low
   input  wire logic               i_chip_en_n,
   input  wire logic               i_proc_addr_strobe_n,
   input  wire logic               i_ctrl_addr_strobe_n,
   input  wire logic               i_burst_advance_n,
   input  wire logic               i_low_byte_wr_n,
   input  wire logic               i_high_byte_wr_n,
   input  wire logic               i_out_en_n,
   // Address
   input  wire logic [ADDR_W-1:0]  i_word_addr_in,
   // Data pins, split three-state
   input  wire logic [DATA_W-1:0]  i_data_io_bus,
   output logic      [DATA_W-1:0]  o_data_io_bus,
   output logic                    o_data_io_bus_oe_n
);
   // Pin synchronisers, then input registers
   logic [ADDR_W-1:0] addr_s1_q, addr_q;
   logic [DATA_W-1:0] din_s1_q, din_q;
   logic [5:0]        ctl_s1_q, ctl_q;
   logic [ADDR_W-1:0] base_q;
   logic [1:0]        cnt_q;
   sram_core_pkg::access_t acc_q;
   logic              burst_q;
   logic [ADDR_W-1:0] mem_addr;
   logic [1:0]        lane_we;
   logic [DATA_W-1:0] rdata;
   logic [DATA_W-1:0] dout_q;
   logic              ce_n, ps_n, cs_n, adv_n, lw_n, hw_n, load;

   always_ff @(posedge i_ref_clk)
   begin
      addr_s1_q <= i_word_addr_in;
      addr_q    <= addr_s1_q;
      din_s1_q  <= i_data_io_bus;
      din_q     <= din_s1_q;
      ctl_s1_q  <= {i_chip_en_n, i_proc_addr_strobe_n, i_ctrl_addr_strobe_n,
                    i_burst_advance_n, i_low_byte_wr_n, i_high_byte_wr_n};
      ctl_q     <= ctl_s1_q;
   end

   assign {ce_n, ps_n, cs_n, adv_n, lw_n, hw_n} = ctl_q;
   assign load = !ps_n || !cs_n;

   // Base address and burst counter
   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset)
      begin
         base_q  <= '0;
         cnt_q   <= '0;
         burst_q <= 1'b0;
      end
      else if (load)
      begin
         base_q  <= addr_q;
         cnt_q   <= '0;
         burst_q <= !ce_n;
      end
      else if (burst_q && !adv_n)
      begin
         cnt_q <= cnt_q + 2'h1;
      end
   end

   // Access type for this cycle
   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset)
      begin
         acc_q <= sram_core_pkg::ST_DESEL;
      end
      else if (load && ce_n)
      begin
         acc_q <= sram_core_pkg::ST_DESEL;
      end
      else if (!ps_n)
      begin
         acc_q <= sram_core_pkg::ST_READ;
      end
      else if (load || burst_q)
      begin
         acc_q <= (!lw_n || !hw_n) ? sram_core_pkg::ST_WRITE
                                   : sram_core_pkg::ST_READ;
      end
      else
      begin
         acc_q <= sram_core_pkg::ST_DESEL;
      end
   end

   // Interleaved address
   assign mem_addr = load ? addr_q
                   : {base_q[ADDR_W-1:`BURST_W],
                      base_q[`BURST_W-1:0] ^ (adv_n ? cnt_q : cnt_q + 2'h1)};

   // Write enables; processor strobe blocks writes
   assign lane_we[0] = !lw_n && ps_n && (load ? !ce_n : burst_q);
   assign lane_we[1] = !hw_n && ps_n && (load ? !ce_n : burst_q);

   sram_array #(.ADDR_W(ADDR_W), .LANE_W(DATA_W/2)) i_sram_array
   (
      .i_ref_clk (i_ref_clk),
      .i_addr    (mem_addr),
      .i_lane_we (lane_we),
      .i_wdata   (din_q),
      .o_rdata   (rdata)
   );

   // Read data register
   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset)
      begin
         dout_q <= '0;
      end
      else if (load ? (!ce_n && (!ps_n || (lw_n && hw_n)))
                    : (burst_q && lw_n && hw_n))
      begin
         dout_q <= rdata;
      end
   end

   assign o_data_io_bus = dout_q;
   // Drive only on read, gated directly by the pin
   assign o_data_io_bus_oe_n = i_out_en_n
                            || (acc_q != sram_core_pkg::ST_READ);
endmodule // sync_burst_sram_core

// ==== test/host_bus_model.sv ====
`timescale 1ns/10ps
module host_bus_model
(
   // Bus
   input  logic [17:0] i_q,
   input  logic        i_oe_n,
   input  logic        i_en,
   input  logic [17:0] i_d,
   output logic [17:0] o_w
);
   // Released lines show inverted host data
   assign o_w = !i_oe_n ? i_q : i_en ? i_d : ~i_d;
endmodule // host_bus_model

// ==== test/sync_burst_sram_core_chk.sv ====
`timescale 1ns/10ps
module sync_burst_sram_core_chk
(
   input logic i_ref_clk, i_reset, i_chip_en_n, i_proc_addr_strobe_n, i_ctrl_addr_strobe_n,
   input logic i_burst_advance_n, i_low_byte_wr_n, i_high_byte_wr_n, i_out_en_n,
   input logic [14:0] i_word_addr_in,
   input logic [17:0] i_data_io_bus, o_data_io_bus,
   input logic o_data_io_bus_oe_n
);
   wire q = i_proc_addr_strobe_n & i_ctrl_addr_strobe_n & i_low_byte_wr_n & i_high_byte_wr_n;
   wire c = !i_ctrl_addr_strobe_n & i_proc_addr_strobe_n & !i_chip_en_n;
   wire r = i_low_byte_wr_n & i_high_byte_wr_n;
   wire p = !i_proc_addr_strobe_n & !i_chip_en_n;
   wire z = o_data_io_bus_oe_n;
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_reset);
   sequence s_q3; q [*3]; endsequence
   sequence s_h3; (q && i_burst_advance_n) [*3]; endsequence
   property p_oe; i_out_en_n |-> z; endproperty
   a_oe: assert property (p_oe) else $error("oe");
   property p_dr; !z |-> !i_out_en_n; endproperty
   a_dr: assert property (p_dr) else $error("dr");
   property p_rd; p ##1 s_q3 ##1 !i_out_en_n |-> !z; endproperty
   a_rd: assert property (p_rd) else $error("rd");
   property p_cr; c && r ##1 s_q3 ##1 !i_out_en_n |-> !z; endproperty
   a_cr: assert property (p_cr) else $error("cr");
   property p_cw; c && !r |-> ##3 z; endproperty
   a_cw: assert property (p_cw) else $error("cw");
   property p_ds; i_chip_en_n && !(i_proc_addr_strobe_n && i_ctrl_addr_strobe_n) ##1 s_q3 |=> z;
   endproperty
   a_ds: assert property (p_ds) else $error("ds");
   property p_wt; p ##1 (q && i_burst_advance_n) [*4] |=> $stable(o_data_io_bus); endproperty
   a_wt: assert property (p_wt) else $error("wt");
   property p_wr; c && !i_low_byte_wr_n && !i_high_byte_wr_n ##1 c && r
      && $stable(i_word_addr_in) ##1 s_h3 |=> o_data_io_bus == $past(i_data_io_bus, 5);
   endproperty
   a_wr: assert property (p_wr) else $error("wr");
endmodule // sync_burst_sram_core_chk
bind sync_burst_sram_core sync_burst_sram_core_chk u_chk (.*);

// ==== test/tb_sync_burst_sram_core.sv ====
`timescale 1ns/10ps
module tb_sync_burst_sram_core;
   logic clk = 0, rst = 1, dh = 0, oe_n;
   logic [6:0] c = 7'h7f;
   logic [14:0] a = '0, b, r;
   logic [17:0] d = '0, q, w, e, mem [int];
   logic [1:0] l;
   int failures = 0, cmp_count = 0;
   always #12.5 clk = ~clk;
   sync_burst_sram_core i_sync_burst_sram_core (.i_ref_clk(clk), .i_reset(rst),
      .i_out_en_n(c[6]), .i_chip_en_n(c[5]), .i_proc_addr_strobe_n(c[4]),
      .i_ctrl_addr_strobe_n(c[3]), .i_burst_advance_n(c[2]), .i_low_byte_wr_n(c[1]),
      .i_high_byte_wr_n(c[0]), .i_word_addr_in(a), .i_data_io_bus(w), .o_data_io_bus(q),
      .o_data_io_bus_oe_n(oe_n));
   host_bus_model u_host (.i_q(q), .i_oe_n(oe_n), .i_en(dh), .i_d(d), .o_w(w));
   function automatic logic [14:0] ba(logic [14:0] x, int k);
      return {x[14:2], x[1:0] ^ 2'(k)};
   endfunction
   task automatic cy(logic [6:0] v, logic [14:0] x, logic [17:0] y);
      @(posedge clk);
      c <= v;
      a <= x;
      d <= y;
      dh <= v[4] && v[1:0] != 2'h3;
   endtask
   task automatic id(int n);
      repeat (n) cy(7'h1f, a, d);
   endtask
   task automatic chk(logic [17:0] g, logic [17:0] x);
      cmp_count++;
      if (g !== x)
      begin
         failures++;
         $display("MISMATCH t=%0t got %h exp %h", $time, g, x);
      end
   endtask
   task give_verdict;
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      #100000;
      failures++;
      give_verdict;
   end
   initial
   begin
      void'($urandom(93166));
      repeat (20) @(posedge clk);
      rst <= 0;
      repeat (20)
      begin
         b = 15'($urandom);
         for (int k = 0; k < 4; k++)
         begin
            e = 18'($urandom);
            mem[ba(b, k)] = e;
            cy(7'h54, ba(b, k), e);
         end
         cy(7'h17, a, d);
         id(4);
         l = 2'($urandom % 3);
         r = ba(b, $urandom);
         e = 18'($urandom);
         mem[r] = {l[0] ? mem[r][17:9] : e[17:9], l[1] ? mem[r][8:0] : e[8:0]};
         cy(7'h54 | l, r, e);
         id(3);
         r = ba(r, 1);
         e = 18'($urandom);
         mem[r] = e;
         cy(7'h0f, r, d);
         cy(7'h5c, a, e);
         id(3);
         cy($urandom % 2 ? 7'h2f : 7'h37, a, d);
         id(3);
         cy(7'h0c, b, d);
         for (int j = 0; j < 8; j++)
         begin
            cy(j < 4 ? 7'h1b : 7'h1f, a, d);
            @(negedge clk);
            if (j > 1) chk(q, mem[ba(b, j > 5 ? 0 : j - 2)]);
            if (j > 1) chk(18'(oe_n), 18'h0);
         end
         cy(7'h0f, b, d);
         id(5);
      end
      give_verdict;
   end
endmodule // tb_sync_burst_sram_core
